// File: banked_timer_pkg.sv
// Package for the banked two-timer control block.
// Assumes an APB slave with 32-bit data; offsets are register indices (byte address = 4x).
package banked_timer_pkg;
   localparam logic [7:0] IDX_IE_MAIN = 8'ha8;
   localparam logic [7:0] IDX_IE_SECOND = 8'ha9;
   localparam logic [7:0] IDX_IP_MAIN = 8'hb8;
   localparam logic [7:0] IDX_IP_SECOND = 8'hb9;
   localparam logic [7:0] IDX_CONTROL = 8'hc8;
   localparam logic [7:0] IDX_MODE = 8'hc9;
   localparam logic [7:0] IDX_RELOAD_LO = 8'hca;
   localparam logic [7:0] IDX_RELOAD_HI = 8'hcb;
   localparam logic [7:0] IDX_COUNT_LO = 8'hcc;
   localparam logic [7:0] IDX_COUNT_HI = 8'hcd;
   localparam logic [7:0] IDX_POINTER = 8'hce;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hd0;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'hd1;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'hd2;
   localparam logic [2:0] PTR_SECOND = 3'h2;
   localparam logic [2:0] PTR_THIRD = 3'h3;
   localparam logic [2:0] PTR_RESET = 3'h2;
   localparam int CTL_OVF = 7;
   localparam int CTL_EXF = 6;
   localparam int CTL_EXEN = 3;
   localparam int CTL_RUN = 2;
   localparam int CTL_CT = 1;
   localparam int CTL_CPRL = 0;
   localparam int MOD_DIV = 7;
   localparam int MOD_OE = 1;
   localparam int MOD_DIR = 0;
   localparam int IE_SECOND_BIT = 5;
   localparam int IE_THIRD_BIT = 6;
   localparam int IP_SECOND_BIT = 5;
   localparam int IP_THIRD_BIT = 6;
   localparam logic [7:0] CTL_MASK_SECOND = 8'hff;
   localparam logic [7:0] CTL_MASK_THIRD = 8'hcf;
   localparam logic [7:0] MOD_MASK = 8'hbf;
   localparam logic [7:0] IP_MAIN_MASK = 8'h7f;
   localparam logic [3:0] DIV_LAST = 4'hb;
   localparam int IRQ_BITS = 4;
endpackage

// File: banked_timer_two_three_ctrl.sv
// Two 16-bit timer/counters behind one banked control/mode register pair, APB slave.
// Assumes pclk at 125 MHz; pin inputs are asynchronous and are synchronised here.
`timescale 1ns/1ns
module banked_timer_two_three_ctrl #(
   parameter int WIDTH = 16
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] count_pin_in,
   output logic [1:0] count_pin_out,
   output logic [1:0] count_pin_oe,
   input wire logic [1:0] trigger_pin,
   output logic second_timer_irq,
   output logic second_timer_irq_high,
   output logic third_timer_irq,
   output logic third_timer_irq_high,
   output logic irq
);
   // Index 0 is the second timer, 1 the third
   logic [7:0] ctl_q [2];
   logic [7:0] ctl_d [2];
   logic [7:0] mod_q [2];
   logic [7:0] mod_d [2];
   logic [WIDTH-1:0] cnt_q [2];
   logic [WIDTH-1:0] cnt_d [2];
   logic [WIDTH-1:0] rld_q [2];
   logic [WIDTH-1:0] rld_d [2];
   logic [2:0] ptr_q, ptr_d;
   logic [7:0] ie_main_q, ie_main_d, ie_sec_q, ie_sec_d;
   logic [7:0] ip_main_q, ip_main_d, ip_sec_q, ip_sec_d;
   localparam int IRQ_BITS_W = banked_timer_pkg::IRQ_BITS;
   logic [IRQ_BITS_W-1:0] ist_q, ist_d, ien_q, ien_d;
   logic [3:0] div_q, div_d;
   logic [1:0] clk_out_q, clk_out_d;
   logic [1:0] cnt_s1_q, cnt_s2_q, cnt_s3_q;
   logic [1:0] trg_s1_q, trg_s2_q, trg_s3_q;
   logic access, wr, bank_ok, bank;
   logic [7:0] idx;
   logic [7:0] wbyte;
   // Per-timer count sources and pin events, bit 0 second timer, bit 1 third
   logic pre_wrap;
   logic [1:0] cnt_fall;
   logic [1:0] trg_fall;
   logic [1:0] tick_v;
   logic [1:0] up_v;
   logic [1:0] evt_v;
   logic [1:0] adv_v;
   logic [1:0] flag_req;
   logic [7:0] bank_byte;

   assign idx = paddr[9:2];
   assign wbyte = pwdata[7:0];
   assign access = psel && penable;
   assign wr = access && pwrite && clk_en;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // Only the second and third banks exist here; other pointer values hit nothing
   assign bank_ok = (ptr_q == banked_timer_pkg::PTR_SECOND) ||
      (ptr_q == banked_timer_pkg::PTR_THIRD);
   assign bank = (ptr_q == banked_timer_pkg::PTR_THIRD);

   // Pin synchronisers: the first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_s1_q <= 2'h3;
         cnt_s2_q <= 2'h3;
         cnt_s3_q <= 2'h3;
      end
      else if (clk_en)
      begin
         cnt_s1_q <= count_pin_in;
         cnt_s2_q <= cnt_s1_q;
         cnt_s3_q <= cnt_s2_q;
      end
   end

   // Trigger pins idle high too; a low reset value would only show a rising edge
   // on the first cycles after reset, which the falling-edge detect ignores
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trg_s1_q <= 2'h3;
         trg_s2_q <= 2'h3;
         trg_s3_q <= 2'h3;
      end
      else if (clk_en)
      begin
         trg_s1_q <= trigger_pin;
         trg_s2_q <= trg_s1_q;
         trg_s3_q <= trg_s2_q;
      end
   end

   // Prescaler wrap marks one system clock in twelve; both timers share it,
   // so their slow ticks fall on the same cycle
   assign pre_wrap = (div_q == banked_timer_pkg::DIV_LAST);

   // Count sources and pin events. Kept apart from the register update so
   // the order of software writes and hardware sets below stays readable.
   always_comb
   begin
      for (int t = 0; t < 2; t++)
      begin
         // Edges are taken between the second and third stage, never the first
         cnt_fall[t] = cnt_s3_q[t] && !cnt_s2_q[t];
         trg_fall[t] = trg_s3_q[t] && !trg_s2_q[t];
         // With the output enabled the pin is ours to drive, so pulses on it
         // are not counted; the timer falls back to its clock source
         if (ctl_q[t][banked_timer_pkg::CTL_CT] && !mod_q[t][banked_timer_pkg::MOD_OE])
         begin
            tick_v[t] = cnt_fall[t];
         end
         else if (mod_q[t][banked_timer_pkg::MOD_DIV])
         begin
            tick_v[t] = 1'b1;
         end
         else
         begin
            tick_v[t] = pre_wrap;
         end
         // Direction enabled: trigger pin high counts up, low counts down
         up_v[t] = !mod_q[t][banked_timer_pkg::MOD_DIR] || trg_s2_q[t];
         // Trigger edges are ignored while the trigger enable is clear
         evt_v[t] = trg_fall[t] && ctl_q[t][banked_timer_pkg::CTL_EXEN];
         // The counter advances only on a tick while its run bit is set
         adv_v[t] = ctl_q[t][banked_timer_pkg::CTL_RUN] && tick_v[t];
      end
   end

   always_comb
   begin
      logic ovf;
      ovf = 1'b0;
      div_d = pre_wrap ? 4'h0 : div_q + 4'h1;
      ptr_d = ptr_q;
      ie_main_d = ie_main_q;
      ie_sec_d = ie_sec_q;
      ip_main_d = ip_main_q;
      ip_sec_d = ip_sec_q;
      ien_d = ien_q;
      ist_d = ist_q;
      clk_out_d = clk_out_q;
      for (int t = 0; t < 2; t++)
      begin
         ctl_d[t] = ctl_q[t];
         mod_d[t] = mod_q[t];
         cnt_d[t] = cnt_q[t];
         rld_d[t] = rld_q[t];
      end
      // Software writes first, so hardware sets below win over a same-cycle clear
      if (wr)
      begin
         unique case (idx)
            banked_timer_pkg::IDX_POINTER: ptr_d = wbyte[2:0];
            banked_timer_pkg::IDX_IE_MAIN: ie_main_d = wbyte;
            banked_timer_pkg::IDX_IE_SECOND: ie_sec_d = wbyte;
            banked_timer_pkg::IDX_IP_MAIN: ip_main_d = wbyte & banked_timer_pkg::IP_MAIN_MASK;
            banked_timer_pkg::IDX_IP_SECOND: ip_sec_d = wbyte;
            banked_timer_pkg::IDX_IRQ_ENABLE: ien_d = wbyte[IRQ_BITS_W-1:0];
            banked_timer_pkg::IDX_IRQ_CLEAR: ist_d = ist_q & ~wbyte[IRQ_BITS_W-1:0];
            banked_timer_pkg::IDX_CONTROL:
               if (bank_ok)
                  ctl_d[bank] = wbyte & (bank ? banked_timer_pkg::CTL_MASK_THIRD
                     : banked_timer_pkg::CTL_MASK_SECOND);
            banked_timer_pkg::IDX_MODE:
               if (bank_ok)
                  mod_d[bank] = wbyte & banked_timer_pkg::MOD_MASK;
            banked_timer_pkg::IDX_RELOAD_LO:
               if (bank_ok)
                  rld_d[bank][7:0] = wbyte;
            banked_timer_pkg::IDX_RELOAD_HI:
               if (bank_ok)
                  rld_d[bank][WIDTH-1:8] = wbyte;
            banked_timer_pkg::IDX_COUNT_LO:
               if (bank_ok)
                  cnt_d[bank][7:0] = wbyte;
            banked_timer_pkg::IDX_COUNT_HI:
               if (bank_ok)
                  cnt_d[bank][WIDTH-1:8] = wbyte;
            default: ;
         endcase
      end
      for (int t = 0; t < 2; t++)
      begin
         ovf = 1'b0;
         if (adv_v[t])
         begin
            if (up_v[t])
            begin
               // Up count wraps from all ones to the reload value
               ovf = (cnt_q[t] == {WIDTH{1'b1}});
               cnt_d[t] = ovf ? rld_q[t] : cnt_q[t] + 1'b1;
            end
            else
            begin
               // Down count wraps to all ones when it meets the reload value
               ovf = (cnt_q[t] == rld_q[t]);
               cnt_d[t] = ovf ? {WIDTH{1'b1}} : cnt_q[t] - 1'b1;
            end
            // Clock output toggles on each overflow
            if (ovf)
               clk_out_d[t] = !clk_out_q[t];
         end
         if (evt_v[t])
         begin
            if (ctl_q[t][banked_timer_pkg::CTL_CPRL])
               rld_d[t] = cnt_q[t];
            else if (!mod_q[t][banked_timer_pkg::MOD_DIR])
               cnt_d[t] = rld_q[t];
            ctl_d[t][banked_timer_pkg::CTL_EXF] = 1'b1;
            ist_d[2*t+1] = 1'b1;
         end
         if (ovf)
         begin
            ctl_d[t][banked_timer_pkg::CTL_OVF] = 1'b1;
            ist_d[2*t] = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int t = 0; t < 2; t++)
         begin
            ctl_q[t] <= 8'h00;
            mod_q[t] <= 8'h00;
            cnt_q[t] <= '0;
            rld_q[t] <= '0;
         end
         div_q <= 4'h0;
         clk_out_q <= 2'h0;
      end
      else if (clk_en)
      begin
         for (int t = 0; t < 2; t++)
         begin
            ctl_q[t] <= ctl_d[t];
            mod_q[t] <= mod_d[t];
            cnt_q[t] <= cnt_d[t];
            rld_q[t] <= rld_d[t];
         end
         div_q <= div_d;
         clk_out_q <= clk_out_d;
      end
   end

   // Pointer, enables, priorities and the status word; the pointer leaves
   // reset on the second timer's bank
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ptr_q <= banked_timer_pkg::PTR_RESET;
         ie_main_q <= 8'h00;
         ie_sec_q <= 8'h00;
         ip_main_q <= 8'h00;
         ip_sec_q <= 8'h00;
         ien_q <= '0;
         ist_q <= '0;
      end
      else if (clk_en)
      begin
         ptr_q <= ptr_d;
         ie_main_q <= ie_main_d;
         ie_sec_q <= ie_sec_d;
         ip_main_q <= ip_main_d;
         ip_sec_q <= ip_sec_d;
         ien_q <= ien_d;
         ist_q <= ist_d;
      end
   end

   // Banked byte for the read mux; a reserved pointer value reads as zero
   // rather than aliasing one of the two banks
   always_comb
   begin
      bank_byte = 8'h00;
      if (bank_ok)
      begin
         unique case (idx)
            banked_timer_pkg::IDX_CONTROL: bank_byte = ctl_q[bank];
            banked_timer_pkg::IDX_MODE: bank_byte = mod_q[bank];
            banked_timer_pkg::IDX_RELOAD_LO: bank_byte = rld_q[bank][7:0];
            banked_timer_pkg::IDX_RELOAD_HI: bank_byte = rld_q[bank][WIDTH-1:8];
            banked_timer_pkg::IDX_COUNT_LO: bank_byte = cnt_q[bank][7:0];
            banked_timer_pkg::IDX_COUNT_HI: bank_byte = cnt_q[bank][WIDTH-1:8];
            default: bank_byte = 8'h00;
         endcase
      end
   end

   // Read mux is combinational; pready is always high, so zero wait states
   always_comb
   begin
      prdata = 32'h0000_0000;
      unique case (idx)
         banked_timer_pkg::IDX_POINTER: prdata[2:0] = ptr_q;
         banked_timer_pkg::IDX_IE_MAIN: prdata[7:0] = ie_main_q;
         banked_timer_pkg::IDX_IE_SECOND: prdata[7:0] = ie_sec_q;
         banked_timer_pkg::IDX_IP_MAIN: prdata[7:0] = ip_main_q;
         banked_timer_pkg::IDX_IP_SECOND: prdata[7:0] = ip_sec_q;
         banked_timer_pkg::IDX_IRQ_STATUS: prdata[IRQ_BITS_W-1:0] = ist_q;
         banked_timer_pkg::IDX_IRQ_ENABLE: prdata[IRQ_BITS_W-1:0] = ien_q;
         banked_timer_pkg::IDX_CONTROL: prdata[7:0] = bank_byte;
         banked_timer_pkg::IDX_MODE: prdata[7:0] = bank_byte;
         banked_timer_pkg::IDX_RELOAD_LO: prdata[7:0] = bank_byte;
         banked_timer_pkg::IDX_RELOAD_HI: prdata[7:0] = bank_byte;
         banked_timer_pkg::IDX_COUNT_LO: prdata[7:0] = bank_byte;
         banked_timer_pkg::IDX_COUNT_HI: prdata[7:0] = bank_byte;
         default: prdata = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      for (int t = 0; t < 2; t++)
      begin
         count_pin_oe[t] = mod_q[t][banked_timer_pkg::MOD_OE];
         count_pin_out[t] = clk_out_q[t] && mod_q[t][banked_timer_pkg::MOD_OE];
      end
   end

   // Per-timer requests from control flags, gated by the CPU enables
   // A timer requests while either of its flags stands; the enable only gates it
   always_comb
   begin
      for (int t = 0; t < 2; t++)
      begin
         flag_req[t] = ctl_q[t][banked_timer_pkg::CTL_OVF] || ctl_q[t][banked_timer_pkg::CTL_EXF];
      end
   end

   assign second_timer_irq = flag_req[0] &&
      ie_main_q[banked_timer_pkg::IE_SECOND_BIT];
   assign third_timer_irq = flag_req[1] &&
      ie_sec_q[banked_timer_pkg::IE_THIRD_BIT];
   assign second_timer_irq_high = ip_main_q[banked_timer_pkg::IP_SECOND_BIT];
   assign third_timer_irq_high = ip_sec_q[banked_timer_pkg::IP_THIRD_BIT];
   assign irq = |(ist_q & ien_q);
endmodule

// File: banked_timer_two_three_ctrl_assertions.sv
// Port-level checker for the banked two-timer control block.
// Assumes one pclk domain and asynchronous active-low presetn.
`timescale 1ns/1ns
module banked_timer_two_three_ctrl_assertions #(
   parameter int WIDTH = 16
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] count_pin_out,
   input wire logic [1:0] count_pin_oe,
   input wire logic second_timer_irq_high,
   input wire logic third_timer_irq_high,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence quiet;
      !(psel && penable && pwrite && clk_en);
   endsequence
   answer_ok_a: assert property (pready && !pslverr)
      else $error("bus answer stalled or errored");
   out_idle_a: assert property ((count_pin_out & ~count_pin_oe) == 2'h0)
      else $error("clock output driven while disabled");
   oe_held_a: assert property (quiet |=> $stable(count_pin_oe))
      else $error("output enable moved without a write");
   flag_sticky_a: assert property (irq ##0 quiet |=> irq)
      else $error("interrupt dropped without a write");
   freeze_hold_a: assert property (!clk_en |=> $stable(count_pin_out))
      else $error("state moved while frozen");
   unmapped_zero_a: assert property (psel && !pwrite && paddr[9:2] == 8'h00 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   prio_two_a: assert property ($changed(second_timer_irq_high) |->
      $past(psel && penable && pwrite && clk_en && paddr[9:2] == 8'hb8))
      else $error("second priority moved without its write");
   prio_three_a: assert property ($changed(third_timer_irq_high) |->
      $past(psel && penable && pwrite && clk_en && paddr[9:2] == 8'hb9))
      else $error("third priority moved without its write");
endmodule

// File: banked_timer_pins_model.sv
// Far-side pins: count pulses and trigger falls on request.
// Assumes requests are one-cycle pulses; pins idle high as if pulled up.
`timescale 1ns/1ns
module banked_timer_pins_model (
   input wire logic pclk,
   input wire logic [1:0] cnt_req,
   input wire logic [1:0] trg_req,
   output logic [1:0] count_pin_in,
   output logic [1:0] trigger_pin
);
   logic [3:0] c[4] = '{default: 4'h0};
   logic [3:0] rq;
   assign rq = {trg_req, cnt_req};
   // Low for eight cycles so the three-stage synchroniser sees each fall
   always_ff @(posedge pclk)
      for (int k = 0; k < 4; k++)
         c[k] <= rq[k] ? 4'h8 : (c[k] != 4'h0 ? c[k] - 4'h1 : 4'h0);
   assign count_pin_in = {c[1] == 4'h0, c[0] == 4'h0};
   assign trigger_pin = {c[3] == 4'h0, c[2] == 4'h0};
endmodule

// File: banked_timer_two_three_ctrl_tb_top.sv
// Self-checking bench: APB master, pin model, register and timer scenarios.
// Assumes the package, checker and pin model are compiled before this file.
`timescale 1ns/1ns
module banked_timer_two_three_ctrl_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r = 32'h2678f222;
   logic pready, pslverr, irq, hi2, hi3, ir2, ir3;
   logic [1:0] cin, cout, coe, trg, creq = 2'h0, treq = 2'h0;
   logic [7:0] q, a, m2, m3;
   int mismatches = 0, comparisons = 0;
   initial forever #4 pclk = ~pclk;
   banked_timer_two_three_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_pin_in(cin),
      .count_pin_out(cout), .count_pin_oe(coe), .trigger_pin(trg), .second_timer_irq(ir2),
      .second_timer_irq_high(hi2), .third_timer_irq(ir3), .third_timer_irq_high(hi3), .irq(irq));
   banked_timer_pins_model i_pins (.pclk(pclk), .cnt_req(creq), .trg_req(treq),
      .count_pin_in(cin), .trigger_pin(trg));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] reg_exp(input logic [7:0] i, input logic [7:0] d);
      if (i == 8'hb8)
         return d & banked_timer_pkg::IP_MAIN_MASK;
      return i == 8'hc9 ? d & banked_timer_pkg::MOD_MASK : d;
   endfunction
   task automatic results;
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {22'h0, i, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      xfer(1'b1, i, d);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [7:0] e, input string n);
      xfer(1'b0, i, 8'h0);
      chk(n, e, q);
   endtask
   task automatic pulse(input logic [1:0] c, input logic [1:0] t);
      creq <= c;
      treq <= t;
      @(posedge pclk);
      creq <= 2'h0;
      treq <= 2'h0;
      repeat (20) @(posedge pclk);
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      results();
   end
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(8'hce, 8'h02, "pointer");
      rdc(8'h00, 8'h00, "unmapped");
      for (int k = 0; k < 4; k++)
      begin
         r = lfsr(r);
         a = {3'h5, k[1], 3'h4, k[0]};
         wr(a, r[7:0]);
         rdc(a, reg_exp(a, r[7:0]), "irq reg");
         if (a[4])
            chk("prio pin", r[a[0] ? 6 : 5], a[0] ? hi3 : hi2);
      end
      wr(8'ha8, 8'h20);
      wr(8'ha9, 8'h40);
      wr(8'hd2, 8'h0f);
      r = lfsr(r);
      m2 = r[7:0];
      m3 = r[15:8];
      wr(8'hc9, m2);
      wr(8'hce, 8'h03);
      wr(8'hc9, m3);
      wr(8'hc8, 8'h30);
      rdc(8'hc8, 8'h00, "ctl reserved");
      rdc(8'hc9, reg_exp(8'hc9, m3), "mode third");
      chk("oe", {m3[1], m2[1]}, coe);
      wr(8'hce, 8'h05);
      rdc(8'hc9, 8'h00, "mode none");
      wr(8'hce, 8'h02);
      rdc(8'hc9, reg_exp(8'hc9, m2), "mode second");
      wr(8'hc9, 8'h00);
      wr(8'hce, 8'h03);
      wr(8'hcc, 8'hff);
      wr(8'hcd, 8'hff);
      wr(8'hc9, 8'h80);
      clk_en <= 1'b0;
      repeat (3) @(posedge pclk);
      clk_en <= 1'b1;
      wr(8'hc8, 8'h04);
      q = 8'h0;
      for (int k = 0; k < 20 && !q[7]; k++)
         xfer(1'b0, 8'hc8, 8'h0);
      chk("overflow", 8'h84, q);
      chk("irq3", 8'h1, ir3);
      rdc(8'hd0, 8'h04, "status");
      wr(8'hc8, 8'h00);
      rdc(8'hc8, 8'h00, "flag clear");
      chk("irq3 off", 8'h0, ir3);
      chk("irq sticky", 8'h1, irq);
      wr(8'hd1, 8'h0f);
      chk("irq cleared", 8'h0, irq);
      xfer(1'b0, 8'hcc, 8'h0);
      a = q;
      repeat (20) @(posedge pclk);
      rdc(8'hcc, a, "stopped");
      wr(8'hce, 8'h02);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hc8, 8'h04);
      repeat (240) @(posedge pclk);
      wr(8'hc8, 8'h00);
      xfer(1'b0, 8'hcc, 8'h0);
      chk("div twelve", 8'h1, q >= 8'd18 && q <= 8'd22);
      wr(8'hcc, 8'h00);
      wr(8'hc8, 8'h06);
      repeat (5) pulse(2'h1, 2'h0);
      rdc(8'hcc, 8'h05, "pulses");
      wr(8'hc8, 8'h00);
      wr(8'hce, 8'h03);
      wr(8'hc8, 8'h09);
      pulse(2'h0, 2'h2);
      rdc(8'hc8, 8'h49, "trigger flag");
      chk("irq3 trig", 8'h1, ir3);
      xfer(1'b0, 8'hcc, 8'h0);
      rdc(8'hca, q, "capture");
      wr(8'hc8, 8'h00);
      pulse(2'h0, 2'h2);
      rdc(8'hc8, 8'h00, "trigger off");
      wr(8'hce, 8'h02);
      wr(8'hc8, 8'h08);
      pulse(2'h0, 2'h1);
      chk("irq2", 8'h1, ir2);
      wr(8'ha8, 8'h00);
      chk("irq2 gated", 8'h0, ir2);
      wr(8'hce, 8'h03);
      wr(8'hc9, 8'h83);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h01);
      wr(8'hc8, 8'h04);
      pulse(2'h0, 2'h2);
      wr(8'hc8, 8'h00);
      xfer(1'b0, 8'hcc, 8'h0);
      chk("down count", 8'h1, q >= 8'd6 && q <= 8'd10);
      chk("oe third", 8'h1, coe[1]);
      a = {7'h0, cout[1]};
      wr(8'hcc, 8'hf0);
      wr(8'hcd, 8'hff);
      wr(8'hc8, 8'h04);
      repeat (30) @(posedge pclk);
      wr(8'hc8, 8'h00);
      chk("clock out", {7'h0, !a[0]}, cout[1]);
      results();
   end
endmodule
bind banked_timer_two_three_ctrl banked_timer_two_three_ctrl_assertions #(.WIDTH(WIDTH)) i_chk (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .count_pin_out(count_pin_out), .count_pin_oe(count_pin_oe), .irq(irq),
   .second_timer_irq_high(second_timer_irq_high), .third_timer_irq_high(third_timer_irq_high));
